/* rtl/flash_seq_map.vh */
/*
 Constants for the flash erase/program sequencer: command codes, data
 values, array geometry and pulse timing. Assumes a 200 MHz system clock.
*/
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

`define CMD_ERASE 8'h20
`define CMD_ERASE_VERIFY 8'hA0
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_VERIFY 8'hC0
`define CMD_READ 8'h00
`define DATA_ERASED 8'hFF
`define DATA_ZERO 8'h00
`define ADDR_FIRST 17'h00000
`define ADDR_LAST 17'h1FFFF
`define PROG_TRIES_MAX 5'h19
`define CLK_MHZ 200
`define PROG_PULSE_US 10
`define PROG_PULSE_CYC (`PROG_PULSE_US * `CLK_MHZ)
`define ERASE_WAIT_US 9500
`define ERASE_WAIT_CYC (`ERASE_WAIT_US * `CLK_MHZ)
`define VERIFY_WAIT_NS 6000
`define VERIFY_WAIT_CYC ((`VERIFY_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYC 24
`define READ_CYC 48

`endif

/* rtl/flash_seq_ctrl.v */
/*
 Host-side controller that erases or programs a byte-wide parallel flash
 through its chip enable, output enable, write enable, address and data
 pins. Assumes the flash high-voltage supply is already up and that the
 data pins are joined by the bench from the three data signals.
*/
`include "flash_seq_map.vh"

// Function
// - Zero every byte before erase pulses
// - Erase needs two consecutive 20h writes
// - A0h write carries address to verify
// - Read after erase verify, compare FFh
// - Verify from 0000h upward until fail
// - On fail, re-erase, resume stored address
// - Repeat 10us program pulses until verified
// - At most 25 program pulses per byte
// - 40h then write latches address, data
// - C0h then read, compare intended data
// - Wait 9.5ms after erase before verify
module flash_seq_ctrl #(
    parameter PULSE_CYC = `PROG_PULSE_CYC,
    parameter ERASE_CYC = `ERASE_WAIT_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire start_erase,
    input wire start_program,
    input wire [16:0] prog_addr,
    input wire [7:0] prog_data,
    output wire busy,
    output reg done_ff,
    output reg fail_ff,
    output reg [16:0] fail_addr_ff,
    output reg [16:0] flash_addr_ff,
    output reg [7:0] flash_dq_out_ff,
    output reg flash_dq_oe_ff,
    input wire [7:0] flash_dq_in,
    output reg flash_ce_n_ff,
    output reg flash_oe_n_ff,
    output reg flash_we_n_ff
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_PSETUP = 4'h1;
    localparam [3:0] S_PWRITE = 4'h2;
    localparam [3:0] S_PPULSE = 4'h3;
    localparam [3:0] S_PVCMD = 4'h4;
    localparam [3:0] S_PVREAD = 4'h5;
    localparam [3:0] S_ESETUP = 4'h6;
    localparam [3:0] S_EGO = 4'h7;
    localparam [3:0] S_EWAIT = 4'h8;
    localparam [3:0] S_EVCMD = 4'h9;
    localparam [3:0] S_EVREAD = 4'hA;
    localparam [3:0] S_RESET_CMD = 4'hB;
    localparam [3:0] S_DONE = 4'hC;

    // Bus cycle sub-steps for a write strobe; reads step on the chip and output enables
    localparam [1:0] B_IDLE = 2'h0;
    localparam [1:0] B_ACT = 2'h1;
    localparam [1:0] B_GAP = 2'h2;

    // Write-to-read recovery, cut to the counter width on purpose
    localparam integer VERIFY_INT = `VERIFY_WAIT_CYC;
    localparam [21:0] VERIFY_CYC = VERIFY_INT[21:0];

    // Sequencer state, wait counter and the byte in hand
    reg [3:0] state_ff;
    reg [1:0] bus_ff;
    reg [21:0] wait_ff;
    reg [4:0] tries_ff;
    reg [16:0] addr_ff;
    reg [7:0] data_ff;
    reg erase_job_ff;
    reg zeroing_ff;
    reg [7:0] rd_meta_ff;
    reg [7:0] rd_sync_ff;

    assign busy = (state_ff != S_IDLE);

    // Read data comes from a pin, so it is synchronised first
    // The two-cycle lag is harmless: data stands long before it is taken
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_meta_ff <= 8'h00;
            rd_sync_ff <= 8'h00;
        end else begin
            rd_meta_ff <= flash_dq_in;
            rd_sync_ff <= rd_meta_ff;
        end
    end

    // Pin drive for a write (command or data); the caller sets the wait
    // counter shared by strobes, pulses and the erase dwell
    task bus_write;
        input [7:0] val;
        input [16:0] adr;
        begin
            flash_addr_ff <= adr;
            flash_dq_out_ff <= val;
            flash_dq_oe_ff <= 1'b1;
            flash_ce_n_ff <= 1'b0;
            flash_we_n_ff <= 1'b0;
        end
    endtask

    // Main sequencer; every wait is counted down in wait_ff
    // A step runs only when the counter is zero and no strobe is open
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
            bus_ff <= B_IDLE;
            wait_ff <= 22'h000000;
            tries_ff <= 5'h00;
            addr_ff <= 17'h00000;
            data_ff <= 8'h00;
            erase_job_ff <= 1'b0;
            zeroing_ff <= 1'b0;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
            fail_addr_ff <= 17'h00000;
            flash_addr_ff <= 17'h00000;
            flash_dq_out_ff <= 8'h00;
            flash_dq_oe_ff <= 1'b0;
            flash_ce_n_ff <= 1'b1;
            flash_oe_n_ff <= 1'b1;
            flash_we_n_ff <= 1'b1;
        end else if (wait_ff != 22'h000000) begin
            wait_ff <= wait_ff - 22'h000001;
        end else if (bus_ff == B_ACT) begin
            // End of strobe: release pins, then a recovery gap
            // The gap also keeps write enable high between back-to-back strobes
            flash_we_n_ff <= 1'b1;
            flash_oe_n_ff <= 1'b1;
            flash_ce_n_ff <= 1'b1;
            flash_dq_oe_ff <= 1'b0;
            bus_ff <= B_GAP;
            wait_ff <= 22'd4;
        end else begin
            bus_ff <= B_IDLE;
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    // Erase wins if both starts are high; starts seen while
                    // busy are dropped without any indication
                    if (start_erase) begin
                        erase_job_ff <= 1'b1;
                        zeroing_ff <= 1'b1;
                        fail_ff <= 1'b0;
                        addr_ff <= `ADDR_FIRST;
                        data_ff <= `DATA_ZERO;
                        tries_ff <= 5'h00;
                        state_ff <= S_PSETUP;
                    end else if (start_program) begin
                        erase_job_ff <= 1'b0;
                        zeroing_ff <= 1'b0;
                        fail_ff <= 1'b0;
                        addr_ff <= prog_addr;
                        data_ff <= prog_data;
                        tries_ff <= 5'h00;
                        state_ff <= S_PSETUP;
                    end
                end
                S_PSETUP: begin
                    // Each set-up starts one program operation, counted here
                    bus_write(`CMD_PROGRAM, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    tries_ff <= tries_ff + 5'h01;
                    state_ff <= S_PWRITE;
                end
                S_PWRITE: begin
                    bus_write(data_ff, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_PPULSE;
                end
                S_PPULSE: begin
                    // Program pulse runs inside the device; margin sensing
                    // is its own concern
                    wait_ff <= PULSE_CYC[21:0];
                    state_ff <= S_PVCMD;
                end
                S_PVCMD: begin
                    // Verify set-up; the read that follows is judged in S_PVREAD
                    bus_write(`CMD_PROGRAM_VERIFY, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_PVREAD;
                end
                S_PVREAD: begin
                    if (flash_ce_n_ff) begin
                        // Select and address first, then the write-to-read
                        // recovery; sensing too early gives unsettled data
                        flash_addr_ff <= addr_ff;
                        flash_ce_n_ff <= 1'b0;
                        wait_ff <= VERIFY_CYC;
                    end else if (flash_oe_n_ff) begin
                        // Output enable, then settle through the synchroniser
                        flash_oe_n_ff <= 1'b0;
                        wait_ff <= 22'd`READ_CYC;
                    end else begin
                        flash_oe_n_ff <= 1'b1;
                        flash_ce_n_ff <= 1'b1;
                        wait_ff <= 22'd4;
                        if (rd_sync_ff == data_ff) begin
                            tries_ff <= 5'h00;
                            if (zeroing_ff && addr_ff != `ADDR_LAST) begin
                                addr_ff <= addr_ff + 17'h00001;
                                state_ff <= S_PSETUP;
                            end else if (zeroing_ff) begin
                                zeroing_ff <= 1'b0;
                                addr_ff <= `ADDR_FIRST;
                                state_ff <= S_ESETUP;
                            end else begin
                                state_ff <= S_RESET_CMD;
                            end
                        end else if (tries_ff >= `PROG_TRIES_MAX) begin
                            // A dead byte in the pre-zero pass aborts the erase
                            fail_ff <= 1'b1;
                            fail_addr_ff <= addr_ff;
                            state_ff <= S_RESET_CMD;
                        end else begin
                            state_ff <= S_PSETUP;
                        end
                    end
                end
                S_ESETUP: begin
                    // Set-up write; the address carries no meaning here
                    bus_write(`CMD_ERASE, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_EGO;
                end
                S_EGO: begin
                    // Second identical write starts the erase
                    bus_write(`CMD_ERASE, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_EWAIT;
                end
                S_EWAIT: begin
                    // Erase runs inside the device; no verify before the dwell ends
                    wait_ff <= ERASE_CYC[21:0];
                    state_ff <= S_EVCMD;
                end
                S_EVCMD: begin
                    // The address in this write picks the byte to check
                    bus_write(`CMD_ERASE_VERIFY, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_EVREAD;
                end
                S_EVREAD: begin
                    if (flash_ce_n_ff) begin
                        // Same read cycle as program verify, recovery first
                        flash_addr_ff <= addr_ff;
                        flash_ce_n_ff <= 1'b0;
                        wait_ff <= VERIFY_CYC;
                    end else if (flash_oe_n_ff) begin
                        // Output enable, then settle through the synchroniser
                        flash_oe_n_ff <= 1'b0;
                        wait_ff <= 22'd`READ_CYC;
                    end else begin
                        flash_oe_n_ff <= 1'b1;
                        flash_ce_n_ff <= 1'b1;
                        wait_ff <= 22'd4;
                        if (rd_sync_ff != `DATA_ERASED) begin
                            // addr_ff keeps the failing byte for resume
                            // Re-erase has no retry limit: a worn array stays busy
                            state_ff <= S_ESETUP;
                        end else if (addr_ff == `ADDR_LAST) begin
                            state_ff <= S_RESET_CMD;
                        end else begin
                            addr_ff <= addr_ff + 17'h00001;
                            state_ff <= S_EVCMD;
                        end
                    end
                end
                S_RESET_CMD: begin
                    // Leave the device in read mode
                    // so that a later plain read sees array data
                    bus_write(`CMD_READ, addr_ff);
                    bus_ff <= B_ACT;
                    wait_ff <= 22'd`STROBE_CYC;
                    state_ff <= S_DONE;
                end
                S_DONE: begin
                    // One-cycle done; fail stands until the next start
                    done_ff <= 1'b1;
                    erase_job_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

endmodule // flash_seq_ctrl

/* test/flash_dev_model.sv */
/* Behavioural byte-wide flash with its command register.
   Assumes the bench resolves the data pins and feeds them to din. */
module flash_dev_model (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [16:0] addr,
    input wire logic [7:0] din,
    input wire logic [7:0] need,
    output logic [7:0] q = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:131071];
    logic [7:0] cmd_ff = 8'h00;
    logic [16:0] vaddr_ff = 17'h00000;
    int tries = 0;
    int pulses = 0;
    int i;
    // Array leaves the factory blank
    initial for (i = 0; i < 131072; i++) mem[i] = 8'hFF;
    // Sample 1 ns after the write strobe falls, so no race with the pins
    always @(negedge we_n) begin
        #1;
        if (!ce_n && cmd_ff == 8'h40) begin
            if (addr != vaddr_ff) tries = 0;
            tries++;
            pulses++;
            vaddr_ff = addr;
            // Margin sensing: a weak cell takes several pulses
            if (tries >= need) mem[addr] = mem[addr] & din;
            cmd_ff = 8'h01;
        end else if (!ce_n && din == 8'h20 && cmd_ff == 8'h20) begin
            for (i = 0; i < 131072; i++) mem[i] = 8'hFF;
            cmd_ff = 8'h01;
        end else if (!ce_n) begin
            if (din == 8'hA0) vaddr_ff = addr;
            cmd_ff = din;
        end
    end
    // Verify reads; a released bus toggles so stale data never matches
    always #1 q = (!ce_n && !oe_n) ? mem[vaddr_ff] : ~q;
endmodule // flash_dev_model

/* test/flash_seq_ctrl_properties.sv */
/* Pin-level checks of the flash sequencer.
   Assumes the top module's ports and its two timing parameters. */
`include "flash_seq_map.vh"
module flash_seq_ctrl_properties #(
    parameter PULSE_CYC = 4,
    parameter ERASE_CYC = 20
) (
    input wire clk_sys,
    input wire rst,
    input wire done_ff,
    input wire fail_ff,
    input wire [16:0] fail_addr_ff,
    input wire [16:0] flash_addr_ff,
    input wire [7:0] flash_dq_out_ff,
    input wire flash_dq_oe_ff,
    input wire flash_ce_n_ff,
    input wire flash_oe_n_ff,
    input wire flash_we_n_ff
);
    reg we_prev_ff;
    reg [31:0] gap_ff;
    reg [7:0] cmd1_ff, cmd2_ff;
    reg [7:0] tries_ff;
    reg [16:0] paddr_ff;
    wire fall = we_prev_ff & ~flash_we_n_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Track write history; tries restart when a new byte is programmed
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            we_prev_ff <= 1'b1;
            gap_ff <= 32'h0;
            cmd1_ff <= 8'h00;
            cmd2_ff <= 8'h00;
            tries_ff <= 8'h00;
            paddr_ff <= 17'h00000;
        end else begin
            we_prev_ff <= flash_we_n_ff;
            gap_ff <= flash_we_n_ff ? gap_ff + 32'h1 : 32'h0;
            if (fall) begin
                cmd1_ff <= flash_dq_out_ff;
                cmd2_ff <= cmd1_ff;
            end
            if (fail_ff || done_ff) tries_ff <= 8'h00;
            else if (fall && cmd1_ff == 8'h40) begin
                tries_ff <= (flash_addr_ff != paddr_ff) ? 8'h01 : tries_ff + 8'h01;
                paddr_ff <= flash_addr_ff;
            end
        end
    end
    chk_write_ce_low: assert property (fall |-> !flash_ce_n_ff && flash_dq_oe_ff)
        else $error("write strobe without chip select or data drive");
    chk_write_held: assert property ($fell(flash_we_n_ff) |=>
        (!flash_we_n_ff && $stable(flash_dq_out_ff) && $stable(flash_addr_ff))[*7])
        else $error("write cycle not held");
    chk_read_no_drive: assert property (!flash_oe_n_ff |-> !flash_dq_oe_ff && flash_we_n_ff)
        else $error("bus driven during read");
    chk_verify_gap: assert property ($fell(flash_oe_n_ff) |-> gap_ff >= `VERIFY_WAIT_CYC)
        else $error("verify read too soon after write");
    chk_erase_wait: assert property (fall && flash_dq_out_ff == 8'hA0 && cmd1_ff == 8'h20
        |-> gap_ff >= ERASE_CYC) else $error("erase verify too early");
    chk_pulse_wait: assert property (fall && flash_dq_out_ff == 8'hC0 && cmd2_ff == 8'h40
        |-> gap_ff >= PULSE_CYC) else $error("program pulse too short");
    chk_tries_limit: assert property (tries_ff <= `PROG_TRIES_MAX)
        else $error("too many program pulses on one byte");
    chk_fail_report: assert property ($rose(fail_ff) |-> tries_ff == 8'd25 && fail_addr_ff == paddr_ff)
        else $error("failure flagged wrongly");
    chk_done_pulse: assert property (done_ff |=> !done_ff) else $error("done longer than one cycle");
    cover property (done_ff && !fail_ff);
    cover property ($rose(fail_ff));
    cover property ($fell(flash_oe_n_ff));
endmodule // flash_seq_ctrl_properties
bind flash_seq_ctrl flash_seq_ctrl_properties #(.PULSE_CYC(PULSE_CYC), .ERASE_CYC(ERASE_CYC))
    u_flash_seq_ctrl_properties (.clk_sys(clk_sys), .rst(rst), .done_ff(done_ff),
    .fail_ff(fail_ff), .fail_addr_ff(fail_addr_ff), .flash_addr_ff(flash_addr_ff),
    .flash_dq_out_ff(flash_dq_out_ff), .flash_dq_oe_ff(flash_dq_oe_ff),
    .flash_ce_n_ff(flash_ce_n_ff), .flash_oe_n_ff(flash_oe_n_ff), .flash_we_n_ff(flash_we_n_ff));

/* test/flash_erase_program_algorithm_test.sv */
/* Self-checking bench: sequencer against the flash model.
   A full erase spans 128K bytes, so only its pre-zero start is run. */
module flash_erase_program_algorithm_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, start_erase = 1'b0, start_program = 1'b0;
    logic [16:0] prog_addr = 17'h00000;
    logic [7:0] prog_data = 8'h00, need = 8'h01;
    int n_errors = 0, n_compared = 0, p0, i;
    wire busy, done, fail, ce_n, oe_n, we_n, dq_oe;
    wire [16:0] fail_addr, f_addr;
    wire [7:0] dq_out, dev_q;
    wire [7:0] dq = dq_oe ? dq_out : dev_q; // Resolved data pins
    always #2.5 clk_sys = ~clk_sys;
    flash_seq_ctrl #(.PULSE_CYC(4), .ERASE_CYC(20)) u_flash_seq_ctrl (.clk_sys(clk_sys),
        .rst(rst), .start_erase(start_erase), .start_program(start_program),
        .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .done_ff(done),
        .fail_ff(fail), .fail_addr_ff(fail_addr), .flash_addr_ff(f_addr),
        .flash_dq_out_ff(dq_out), .flash_dq_oe_ff(dq_oe), .flash_dq_in(dq),
        .flash_ce_n_ff(ce_n), .flash_oe_n_ff(oe_n), .flash_we_n_ff(we_n));
    flash_dev_model u_flash_dev_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
        .din(dq), .need(need), .q(dev_q));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One-cycle start request
    task start(input logic er, input logic [16:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        start_erase <= er;
        start_program <= !er;
        prog_addr <= a;
        prog_data <= d;
        @(posedge clk_sys);
        start_erase <= 1'b0;
        start_program <= 1'b0;
    endtask
    // Bounded wait for the end of a job; done closes failed jobs too
    task wait_end(input int n);
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
            if (done === 1'b1) break;
        end
        if (i == n) begin
            n_errors++;
            wrap_up;
        end
    endtask
    // Weak cell needs three pulses; a start while busy must be ignored
    task t_prog_ok;
        need = 8'h03;
        p0 = u_flash_dev_model.pulses;
        start(1'b0, 17'h0ABCD, 8'h5A);
        start(1'b0, 17'h00077, 8'h11);
        wait_end(20000);
        check(u_flash_dev_model.mem[17'h0ABCD], 8'h5A);
        check(u_flash_dev_model.pulses - p0, 3);
        check(fail, 1'b0);
        check(u_flash_dev_model.mem[17'h00077], 8'hFF);
        $display("t_prog_ok done");
    endtask
    // Dead cell: exactly 25 pulses, then failure with its address
    task t_prog_fail;
        need = 8'hFF;
        p0 = u_flash_dev_model.pulses;
        start(1'b0, 17'h01234, 8'h3C);
        wait_end(60000);
        check(fail, 1'b1);
        check(fail_addr, 17'h01234);
        check(u_flash_dev_model.pulses - p0, 25);
        $display("t_prog_fail done");
    endtask
    // Erase zeroes bytes upward from the bottom first; reset in mid-run
    task t_erase_zero;
        need = 8'h01;
        start(1'b1, 17'h00000, 8'h00);
        for (p0 = 0; p0 < 8000 && u_flash_dev_model.mem[1] !== 8'h00; p0++) @(posedge clk_sys);
        if (p0 == 8000) begin
            n_errors++;
            wrap_up;
        end
        check(u_flash_dev_model.mem[0], 8'h00);
        check(u_flash_dev_model.mem[2], 8'hFF);
        check(busy, 1'b1);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check({busy, we_n, ce_n}, 3'h3);
        $display("t_erase_zero done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_prog_ok;
        t_prog_fail;
        t_erase_zero;
        wrap_up;
    end
endmodule // flash_erase_program_algorithm_test
